// ### hdl/dri_host.sv
`timescale 1ns/1ns
// Summary of operation
// - A 14-bit word address is sent as row then column halves.
// - Address lines are stable before each row and column strobe fall.
// - Early write holds the input bit around the column strobe fall.
// - Delayed write holds the input bit around the store select fall.
// - Every row is refreshed at least once every two milliseconds.
// - Refresh strobes each of 128 rows with column strobe high.
// - Page mode strobes several columns under one held row strobe.
// - Eight dummy cycles run after power-up before normal use.
// - Row strobe stays low between 150 ns and 10,000 ns.
// - Row strobe stays high at least 100 ns between active periods.
module dri_host (
  // Clock and reset.
  input  wire logic            CORE_CLK,
  input  wire logic            RESETN,
  // Request port.
  input  wire logic            REQ_VALID,
  input  wire dri_pkg::dri_req_t REQ,
  output logic                 REQ_READY,
  output logic                 RD_VALID,
  output logic                 RD_DATA,
  output logic                 INIT_DONE,
  // Memory pins.
  output dri_pkg::dri_pins_t   MEM_OUT,
  input  wire logic            MEM_Q
);
  dri_pkg::dri_state_t state_reg;
  dri_pkg::dri_pins_t  pins_reg;
  dri_pkg::dri_req_t   req_reg;
  logic [2:0]          cnt_reg;
  logic [7:0]          ras_cnt_reg;
  logic [7:0]          ref_tmr_reg;
  logic [8:0]          ref_age_reg;
  logic [6:0]          ref_row_reg;
  logic [3:0]          warm_cnt_reg;
  logic                ref_due_reg;
  logic                ref_cyc_reg;
  logic                pend_reg;
  logic                ready_reg;
  logic                rd_valid_reg;
  logic                rd_data_reg;
  logic                init_done_reg;
  logic                q_s1_reg;
  logic                q_s2_reg;
  logic                accept;
  logic                ref_start;
  logic                same_row;
  logic                budget_ok;

  assign accept    = ready_reg && REQ_VALID;
  assign ref_start = (state_reg == dri_pkg::ST_IDLE) && !accept &&
                     (ref_due_reg || !init_done_reg);
  assign same_row  = REQ.addr[13:7] == req_reg.addr[13:7];
  assign budget_ok = (int'(ras_cnt_reg) + dri_pkg::PAGE_COST_CYC + 2)
                     < dri_pkg::TRAS_MAX_CYC;

  assign MEM_OUT   = pins_reg;
  assign REQ_READY = ready_reg;
  assign RD_VALID  = rd_valid_reg;
  assign RD_DATA   = rd_data_reg;
  assign INIT_DONE = init_done_reg;

  // The data output pin floats outside reads, so it is only synchronised.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q_s1_reg <= 1'h0;
      q_s2_reg <= 1'h0;
    end else begin
      q_s1_reg <= MEM_Q;
      q_s2_reg <= q_s1_reg;
    end
  end

  // Refresh pacing; a tick in the cycle of the clear keeps the request.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_tmr_reg <= 8'h00;
      ref_due_reg <= 1'h0;
      ref_age_reg <= 9'h000;
    end else begin
      if (ref_tmr_reg == 8'(dri_pkg::REF_INT_CYC - 1)) begin
        ref_tmr_reg <= 8'h00;
        ref_due_reg <= 1'h1;
      end else begin
        ref_tmr_reg <= ref_tmr_reg + 8'h01;
        if (ref_start)
          ref_due_reg <= 1'h0;
      end
      if (ref_start)
        ref_age_reg <= 9'h000;
      else if (ref_age_reg != 9'h1FF)
        ref_age_reg <= ref_age_reg + 9'h001;
    end
  end

  // Row strobe low time, used to stop paging before the longest width.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN)
      ras_cnt_reg <= 8'h00;
    else if (pins_reg.ras_n)
      ras_cnt_reg <= 8'h00;
    else
      ras_cnt_reg <= ras_cnt_reg + 8'h01;
  end

  // Warm-up: the first refresh cycles double as the dummy cycles.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      warm_cnt_reg  <= 4'h0;
      init_done_reg <= 1'h0;
    end else begin
      if (ref_start && warm_cnt_reg != 4'(dri_pkg::WARMUP_CYCLES))
        warm_cnt_reg <= warm_cnt_reg + 4'h1;
      if (warm_cnt_reg == 4'(dri_pkg::WARMUP_CYCLES) &&
          state_reg == dri_pkg::ST_IDLE)
        init_done_reg <= 1'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg    <= dri_pkg::ST_IDLE;
      pins_reg     <= dri_pkg::PINS_RESET;
      req_reg      <= '0;
      cnt_reg      <= 3'h0;
      ref_row_reg  <= 7'h00;
      ref_cyc_reg  <= 1'h0;
      pend_reg     <= 1'h0;
      ready_reg    <= 1'h0;
      rd_valid_reg <= 1'h0;
      rd_data_reg  <= 1'h0;
    end else begin
      rd_valid_reg <= 1'h0;
      cnt_reg      <= cnt_reg + 3'h1;
      unique case (state_reg)
        dri_pkg::ST_IDLE: begin
          ready_reg <= init_done_reg && !ref_due_reg;
          if (accept) begin
            req_reg     <= REQ;
            ready_reg   <= 1'h0;
            ref_cyc_reg <= 1'h0;
            pins_reg.muxed_line_bus <= REQ.addr[13:7];
            state_reg   <= dri_pkg::ST_ROW;
          end else if (ref_start) begin
            ready_reg   <= 1'h0;
            ref_cyc_reg <= 1'h1;
            pins_reg.muxed_line_bus <= ref_row_reg;
            state_reg   <= dri_pkg::ST_ROW;
          end
        end
        dri_pkg::ST_ROW: begin
          pins_reg.ras_n <= 1'h0;
          cnt_reg        <= 3'h0;
          state_reg      <= dri_pkg::ST_RASLO;
        end
        dri_pkg::ST_RASLO: begin
          if (ref_cyc_reg) begin
            if (cnt_reg == 3'(dri_pkg::TRAS_MIN_CYC - 1)) begin
              pins_reg.ras_n <= 1'h1;
              ref_row_reg    <= ref_row_reg + 7'h01;
              cnt_reg        <= 3'h0;
              state_reg      <= dri_pkg::ST_PRE;
            end
          end else begin
            pins_reg.muxed_line_bus <= req_reg.addr[6:0];
            pins_reg.we_n <= req_reg.op != dri_pkg::DRI_OP_WRITE;
            pins_reg.d    <= req_reg.wdata;
            state_reg     <= dri_pkg::ST_COL;
          end
        end
        dri_pkg::ST_COL: begin
          pins_reg.cas_n <= 1'h0;
          cnt_reg        <= 3'h0;
          state_reg      <= dri_pkg::ST_CASLO;
        end
        dri_pkg::ST_CASLO: begin
          // Long enough for access time plus the input synchroniser.
          if (cnt_reg == 3'(dri_pkg::CAS_LO_CYC - 1)) begin
            if (req_reg.op != dri_pkg::DRI_OP_WRITE) begin
              rd_valid_reg <= 1'h1;
              rd_data_reg  <= q_s2_reg;
            end
            if (req_reg.op == dri_pkg::DRI_OP_RMW) begin
              pins_reg.we_n <= 1'h0;
              state_reg     <= dri_pkg::ST_WRSTB;
            end else begin
              pins_reg.cas_n <= 1'h1;
              pins_reg.we_n  <= 1'h1;
              ready_reg      <= budget_ok && !ref_due_reg;
              state_reg      <= dri_pkg::ST_PRE;
              pend_reg       <= 1'h1;
            end
          end
        end
        dri_pkg::ST_WRSTB: begin
          pins_reg.cas_n <= 1'h1;
          pins_reg.we_n  <= 1'h1;
          ready_reg      <= budget_ok && !ref_due_reg;
          state_reg      <= dri_pkg::ST_PRE;
          pend_reg       <= 1'h1;
        end
        dri_pkg::ST_PRE: begin
          // With pend_reg set and the row still low, this is the page
          // window; otherwise it is the row precharge.
          if (pend_reg && !pins_reg.ras_n) begin
            ready_reg <= 1'h0;
            pend_reg  <= 1'h0;
            cnt_reg   <= 3'h0;
            if (accept) begin
              req_reg <= REQ;
              if (same_row) begin
                pins_reg.muxed_line_bus <= REQ.addr[6:0];
                pins_reg.we_n <= REQ.op != dri_pkg::DRI_OP_WRITE;
                pins_reg.d    <= REQ.wdata;
                state_reg     <= dri_pkg::ST_COL;
              end else begin
                pend_reg       <= 1'h1;
                pins_reg.ras_n <= 1'h1;
              end
            end else begin
              pins_reg.ras_n <= 1'h1;
            end
          end else if (cnt_reg >= 3'(dri_pkg::TRP_CYC - 1)) begin
            pend_reg <= 1'h0;
            if (pend_reg) begin
              ref_cyc_reg <= 1'h0;
              pins_reg.muxed_line_bus <= req_reg.addr[13:7];
              state_reg   <= dri_pkg::ST_ROW;
            end else begin
              ready_reg <= init_done_reg && !ref_due_reg;
              state_reg <= dri_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_ras_min_width: assert property (
    $fell(pins_reg.ras_n) |-> !pins_reg.ras_n[*2])
    else $error("Row strobe low shorter than its least width.");
  a_ras_max_width: assert property (
    ras_cnt_reg < 8'(dri_pkg::TRAS_MAX_CYC))
    else $error("Row strobe low longer than its longest width.");
  a_ras_precharge: assert property (
    $rose(pins_reg.ras_n) |=> pins_reg.ras_n)
    else $error("Row strobe precharge too short.");
  a_addr_row_stable: assert property (
    $fell(pins_reg.ras_n) |-> $stable(pins_reg.muxed_line_bus))
    else $error("Address moved at the row strobe fall.");
  a_addr_col_stable: assert property (
    $fell(pins_reg.cas_n) |-> $stable(pins_reg.muxed_line_bus))
    else $error("Address moved at the column strobe fall.");
  a_early_write_data: assert property (
    $fell(pins_reg.cas_n) && !pins_reg.we_n |->
      $past(!pins_reg.we_n) && $stable(pins_reg.d) ##1 $stable(pins_reg.d))
    else $error("Early write data or select not set before strobe.");
  a_refresh_cas_high: assert property (
    ref_cyc_reg && !pins_reg.ras_n |-> pins_reg.cas_n)
    else $error("Column strobe asserted during refresh.");
  a_cas_inside_ras: assert property (
    !pins_reg.cas_n |-> !pins_reg.ras_n ##1 !pins_reg.ras_n)
    else $error("Column strobe low without a held row strobe.");
  a_refresh_rate: assert property (
    ref_age_reg < 9'(2 * dri_pkg::REF_INT_CYC - 50))
    else $error("Refresh interval overrun.");
  a_warmup_first: assert property (
    accept |-> warm_cnt_reg == 4'(dri_pkg::WARMUP_CYCLES))
    else $error("Access taken before the warm-up cycles.");
  a_read_delay: assert property (
    $fell(pins_reg.cas_n) && pins_reg.we_n |-> ##4 rd_valid_reg)
    else $error("Read data not returned on time.");

  c_read: cover property (rd_valid_reg && req_reg.op == dri_pkg::DRI_OP_READ);
  c_rmw: cover property (state_reg == dri_pkg::ST_WRSTB);
  c_page: cover property ($fell(pins_reg.cas_n) && $past(!pins_reg.ras_n, 4));
  c_refresh: cover property (
    $fell(pins_reg.ras_n) && ref_cyc_reg && init_done_reg);
endmodule : dri_host

// ### hdl/dri_pkg.sv
package dri_pkg;
  // Clock and array geometry.
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W        = 14;
  localparam int HALF_W        = 7;
  localparam int ROW_COUNT     = 128;
  localparam int SYNC_STAGES   = 2;
  localparam int WARMUP_CYCLES = 8;
  // Strobe timing of the fastest grade, in nanoseconds; refresh period in milliseconds.
  localparam int TRAS_MIN_NS = 150;
  localparam int TRAS_MAX_NS = 10000;
  localparam int TRP_NS      = 100;
  localparam int TCAC_NS     = 100;
  localparam int TRAC_NS     = 150;
  localparam int TREF_MS     = 2;
  // Cycle counts: least times round up, longest times round down.
  localparam int TRAS_MIN_CYC =
    (TRAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRAS_MAX_CYC = TRAS_MAX_NS / CLK_PERIOD_NS;
  localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCAC_CYC = (TCAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRAC_CYC = (TRAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_INT_CYC =
    (TREF_MS * 1000000 / ROW_COUNT) / CLK_PERIOD_NS;
  localparam int CAS_LO_CYC    = TCAC_CYC + 1 + SYNC_STAGES;
  localparam int PAGE_COST_CYC = CAS_LO_CYC + 3;
  // Field positions of the word address.
  localparam int ROW_LSB = HALF_W;
  localparam int COL_LSB = 0;

  typedef enum logic [1:0] {
    DRI_OP_READ  = 2'h0,
    DRI_OP_WRITE = 2'h1,
    DRI_OP_RMW   = 2'h2
  } dri_op_t;

  typedef struct packed {
    dri_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic                wdata;
  } dri_req_t;

  typedef struct packed {
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic                d;
    logic [HALF_W-1:0]   muxed_line_bus;
  } dri_pins_t;

  localparam dri_pins_t PINS_RESET = '{ras_n: 1'h1, cas_n: 1'h1,
    we_n: 1'h1, d: 1'h0, muxed_line_bus: 7'h00};

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ROW   = 7'h02,
    ST_RASLO = 7'h04,
    ST_COL   = 7'h08,
    ST_CASLO = 7'h10,
    ST_WRSTB = 7'h20,
    ST_PRE   = 7'h40
  } dri_state_t;
endpackage : dri_pkg

// ### tb/dri_host_test.sv
`timescale 1ns/1ns
module dri_host_test;
  logic               core_clk;
  logic               resetn;
  logic               req_valid;
  dri_pkg::dri_req_t  req;
  logic               req_ready;
  logic               rd_valid;
  logic               rd_data;
  logic               init_done;
  dri_pkg::dri_pins_t mem_out;
  logic               mem_q;
  int                 model_err;
  int                 n_fail;
  int                 cmp_count;
  logic [31:0]        seed;
  logic               shadow [0:16383];

  dri_host dut (.CORE_CLK(core_clk), .RESETN(resetn), .REQ_VALID(req_valid),
    .REQ(req), .REQ_READY(req_ready), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .INIT_DONE(init_done), .MEM_OUT(mem_out),
    .MEM_Q(mem_q));

  dri_mem_model partner (.ras_n(mem_out.ras_n), .cas_n(mem_out.cas_n),
    .we_n(mem_out.we_n), .d(mem_out.d), .bus(mem_out.muxed_line_bus),
    .q(mem_q), .err_cnt(model_err));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Only a request raised before the page window can reuse the open row.
  task automatic access(input dri_pkg::dri_op_t op,
                        input logic [13:0] a, input logic wd);
    int   n;
    logic exp;
    n = 0;
    exp = shadow[a];
    req_valid <= 1'h1;
    req <= '{op: op, addr: a, wdata: wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (req_ready !== 1'h1 && n < 400);
    req_valid <= 1'h0;
    check(n < 400, 1'h1, "request never taken");
    if (op != dri_pkg::DRI_OP_READ) shadow[a] = wd;
    n = 0;
    if (op == dri_pkg::DRI_OP_WRITE) @(posedge core_clk);
    else begin
      do begin
        @(posedge core_clk);
        n++;
      end while (rd_valid !== 1'h1 && n < 40);
      check(rd_data, exp, "read bit");
      check(n == 8 || n == 6 || n == 9, 1'h1, "read latency");
    end
  endtask : access

  initial begin
    core_clk = 1'h0;
    forever #(dri_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  initial begin
    #(60000 * dri_pkg::CLK_PERIOD_NS);
    n_fail++;
    give_verdict();
  end

  initial begin
    int          n;
    logic [13:0] a;
    logic [1:0]  op;
    resetn = 1'h0;
    req_valid = 1'h0;
    req = '0;
    n_fail = 0;
    cmp_count = 0;
    seed = 32'h41;
    for (int i = 0; i < 16384; i++) shadow[i] = 1'h0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (init_done !== 1'h1 && n < 100);
    check(init_done, 1'h1, "warm-up never ended");
    check(req_ready, 1'h0, "ready during warm-up");
    $display("test warmup done");
    access(dri_pkg::DRI_OP_WRITE, 14'h0000, 1'h1);
    access(dri_pkg::DRI_OP_WRITE, 14'h3FFF, 1'h1);
    access(dri_pkg::DRI_OP_READ, 14'h0000, 1'h0);
    access(dri_pkg::DRI_OP_READ, 14'h007F, 1'h1);
    access(dri_pkg::DRI_OP_READ, 14'h3F80, 1'h1);
    access(dri_pkg::DRI_OP_RMW, 14'h3FFF, 1'h0);
    access(dri_pkg::DRI_OP_READ, 14'h3FFF, 1'h1);
    $display("test corners done");
    repeat (400) begin
      seed = xorshift(seed);
      op = (seed[1:0] == 2'h3) ? 2'h0 : seed[1:0];
      a = {5'h00, seed[9:8], seed[16:10]};
      access(dri_pkg::dri_op_t'(op), a, seed[20]);
    end
    $display("test random done");
    repeat (21000) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      a = {5'h00, i[1:0], 7'h00};
      access(dri_pkg::DRI_OP_READ, a, 1'h0);
    end
    check(model_err == 0, 1'h1, "memory protocol fault");
    $display("test refresh done");
    give_verdict();
  end
endmodule : dri_host_test

// ### tb/dri_mem_model.sv
`timescale 1ns/1ns
module dri_mem_model (
  // Memory pins.
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       d,
  input  wire logic [dri_pkg::HALF_W-1:0] bus,
  output logic                            q,
  // Protocol faults seen.
  output int                              err_cnt
);
  logic                       mem [0:16383];
  logic [dri_pkg::ADDR_W-1:0] adr;
  logic [dri_pkg::HALF_W-1:0] row;
  logic                       rd;
  logic                       shown;
  logic                       qbit;
  int                         ras_cnt;
  time                        t_fall;
  time                        t_rise;
  time                        dly;
  time                        t_ref [0:dri_pkg::ROW_COUNT-1];

  initial begin
    err_cnt = 0;
    ras_cnt = 0;
    rd = 1'h0;
    shown = 1'h0;
    qbit = 1'h0;
    t_fall = 0;
    t_rise = 0;
    for (int i = 0; i < 16384; i++) mem[i] = 1'h0;
    for (int i = 0; i < dri_pkg::ROW_COUNT; i++) t_ref[i] = 0;
  end

  always @(negedge ras_n) begin
    row = bus;
    if (ras_cnt > 0 && $time - t_rise < dri_pkg::TRP_NS) err_cnt++;
    if (cas_n !== 1'h1) err_cnt++;
    if ($time - t_ref[bus] > dri_pkg::TREF_MS * 1000000) err_cnt++;
    t_ref[bus] = $time;
    t_fall = $time;
    ras_cnt++;
  end

  always @(posedge ras_n) if (ras_cnt > 0) begin
    if ($time - t_fall < dri_pkg::TRAS_MIN_NS) err_cnt++;
    if ($time - t_fall > dri_pkg::TRAS_MAX_NS) err_cnt++;
    t_rise = $time;
  end

  // A column access before warm-up ends is counted, not refused.
  always @(negedge cas_n) if (ras_n === 1'h0) begin
    adr = {row, bus};
    if (ras_cnt <= dri_pkg::WARMUP_CYCLES) err_cnt++;
    rd = we_n;
    if (!we_n) mem[adr] = d;
    shown = 1'h0;
    dly = dri_pkg::TCAC_NS;
    if ($time - t_fall < dri_pkg::TRAC_NS - dri_pkg::TCAC_NS)
      dly = t_fall + dri_pkg::TRAC_NS - $time;
    #(dly);
    qbit = mem[adr];
    shown = rd && !cas_n;
  end

  always @(negedge we_n) if (!cas_n && !ras_n && rd) mem[adr] = d;
  always @(posedge cas_n) shown = 1'h0;

  // No pull on the wire, so a floating output shows the inverse bit.
  assign q = shown ? qbit : ~qbit;
endmodule : dri_mem_model
